// ==== ciadc_pkg.sv ====
// Package for the two-wire converter controller: field layout, reset values,
// timing counts and the state types of the link-side sequencer.
// Assumes the core clock runs at 100 MHz; the link clock is an unrelated clock.
package ciadc_pkg;

  // ---------------------------------------------------------------------------
  // Control register layout and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL_AOE_BIT = 6;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_AINC_BIT = 2;
  localparam int CTRL_CHAN_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DAC_RESET = 8'h00;
  localparam logic [7:0] ADC_RESET = 8'h80;
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

  // Default for the fixed upper address bits; the value is arbitrary.
  localparam logic [3:0] ADDR_FIXED_DEFAULT = 4'h5;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_HALF_NS = 500;
  localparam int OSC_HALF_CYC = OSC_HALF_NS / CLK_PERIOD_NS;
  localparam logic [7:0] OSC_HALF_LAST = 8'(OSC_HALF_CYC - 1);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CIADC_MODE_SE4,
    CIADC_MODE_DIFF3,
    CIADC_MODE_MIXED,
    CIADC_MODE_DIFF2
  } ciadc_mode_e;

  typedef enum {
    LK_IDLE,
    LK_ADDR,
    LK_ADDR_ACK,
    LK_WR_BYTE,
    LK_WR_ACK,
    LK_RD_BYTE,
    LK_RD_ACK,
    LK_RD_ACKED,
    LK_WAIT_STOP
  } ciadc_link_e;

  // Highest channel number that exists in an input mode.
  function automatic logic [1:0] chan_max(input logic [1:0] mode);
    logic [1:0] m;
    m = 2'h3;
    unique case (mode)
      CIADC_MODE_SE4: m = 2'h3;
      CIADC_MODE_DIFF3: m = 2'h2;
      CIADC_MODE_MIXED: m = 2'h2;
      CIADC_MODE_DIFF2: m = 2'h1;
    endcase
    return m;
  endfunction

  // Channel actually converted: a missing channel maps to the highest one.
  function automatic logic [1:0] chan_eff(input logic [7:0] ctrl);
    logic [1:0] mx;
    mx = chan_max(ctrl[CTRL_MODE_LSB +: 2]);
    return (ctrl[CTRL_CHAN_LSB +: 2] > mx) ? mx : ctrl[CTRL_CHAN_LSB +: 2];
  endfunction

  // True when the channel in this mode is a differential pair.
  function automatic logic chan_is_diff(input logic [1:0] mode, input logic [1:0] chan);
    logic d;
    d = 1'b0;
    unique case (mode)
      CIADC_MODE_SE4: d = 1'b0;
      CIADC_MODE_DIFF3: d = 1'b1;
      CIADC_MODE_MIXED: d = (chan == 2'h2);
      CIADC_MODE_DIFF2: d = 1'b1;
    endcase
    return d;
  endfunction

endpackage

// ==== ciadc_sar.sv ====
// Successive-approximation sequencer for the converter core.
// Assumes a one-cycle start pulse, a step pulse per conversion clock period
// and a comparator level already synchronised to this clock.
`timescale 1ns/1ps
module ciadc_sar (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic step,
  input wire logic comp_high,
  output logic busy,
  output logic [7:0] trial,
  output logic [7:0] result,
  output logic done
);

  // ---------------------------------------------------------------------------
  // Bit-by-bit search
  // ---------------------------------------------------------------------------
  logic [7:0] bit_mask_r;
  logic settle_r;

  // Each step keeps or drops the bit under test, then tries the next lower one.
  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
      trial <= 8'h00;
      bit_mask_r <= 8'h00;
      settle_r <= 1'b0;
      result <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        settle_r <= 1'b1;
        trial <= ciadc_pkg::SAR_FIRST_TRIAL;
        bit_mask_r <= ciadc_pkg::SAR_FIRST_TRIAL;
      end else if (busy && step && settle_r) begin
        // The first step only lets the comparator settle on the first trial.
        settle_r <= 1'b0;
      end else if (busy && step) begin
        if (bit_mask_r == 8'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= comp_high ? trial : (trial & ~bit_mask_r);
        end else begin
          trial <= (comp_high ? trial : (trial & ~bit_mask_r)) | (bit_mask_r >> 1);
          bit_mask_r <= bit_mask_r >> 1;
        end
      end
    end
  end

endmodule

// ==== ciadc_top.sv ====
// Converter controller: two-wire slave on the link clock, control, DAC and
// ADC registers with the conversion sequencer on the core clock.
// Assumes scl, sda and all straps are asynchronous pins; the comparator and
// the oscillator pin come from outside the core domain as well.
//
// Contract
// - First data byte of write loads control register.
// - Upper nibble: output enable, input mode; lower: channel.
// - Bit 6 enables output, keeps oscillator running.
// - Auto-increment advances channel after each conversion.
// - Missing channel maps highest; then wraps to zero.
// - Reset clears control, disables oscillator, output off.
// - Second data byte loads DAC tap value.
// - Output enable gates buffer; value held until rewritten.
// - Conversion borrows DAC; output held meanwhile.
// - Conversion starts at read acknowledge trailing edge.
// - Single-ended straight binary, differential two's complement.
// - Result stored; read returns previous cycle's result.
// - First byte after reset reads 80 hex.
// - Source select: internal drives pin, else pin input; the pin floats while the internal oscillator is stopped.
// - SDA changes only while SCL low, except start/stop.
// - Detect start and stop while SCL high.
// - Pull SDA low on ninth clock after receiving.
// - On master no-acknowledge, release SDA for stop.
// - Stop or repeated start closes a write.
// - Address is fixed bits plus three select pins.
`timescale 1ns/1ps
module ciadc_top #(
  parameter logic [3:0] ADDR_FIXED = ciadc_pkg::ADDR_FIXED_DEFAULT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic address_select_0,
  input wire logic address_select_1,
  input wire logic address_select_2,
  input wire logic clock_source_select,
  input wire logic oscillator_pin_i,
  output logic oscillator_pin_o,
  output logic oscillator_pin_oe_n,
  input wire logic comparator_high,
  output logic [7:0] dac_tap,
  output logic analog_output_enable,
  output logic track_hold,
  output logic sample_strobe,
  output logic [1:0] channel_select,
  output logic [1:0] input_mode,
  output logic osc_enable,
  output logic adc_busy,
  output logic [7:0] control_value
);

  // ---------------------------------------------------------------------------
  // Link domain: synchronisers
  // ---------------------------------------------------------------------------
  logic rst_l_m, rst_l;
  logic scl_m, scl_s, scl_q;
  logic sda_m, sda_s, sda_q;
  logic [2:0] asel_m, asel_s;
  logic done_m, done_s, done_q;
  logic done_tgl_r;
  logic [7:0] adc_result_r;

  // Pins, the core reset and the result toggle pass two flops first.
  always_ff @(posedge link_clk) begin
    rst_l_m <= rst;
    rst_l <= rst_l_m;
    scl_m <= scl;
    scl_s <= scl_m;
    scl_q <= scl_s;
    sda_m <= sda_i;
    sda_s <= sda_m;
    sda_q <= sda_s;
    asel_m <= {address_select_2, address_select_1, address_select_0};
    asel_s <= asel_m;
    done_m <= done_tgl_r;
    done_s <= done_m;
    done_q <= done_s;
  end

  logic start_ev, stop_ev, scl_rise, scl_fall;

  // Line events decoded from the synchronised levels.
  assign start_ev = scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;

  // ---------------------------------------------------------------------------
  // Link domain: byte sequencer
  // ---------------------------------------------------------------------------
  ciadc_pkg::ciadc_link_e lk_state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic [1:0] wr_idx_r;
  logic [7:0] wr_ctrl_byte_r;
  logic [7:0] wr_dac_byte_r;
  logic ctrl_tgl_r, dac_tgl_r, conv_tgl_r;
  logic [7:0] last_res_r;

  // Receives address and write bytes, answers acknowledges, sends results.
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      lk_state_r <= ciadc_pkg::LK_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      wr_idx_r <= 2'h0;
      wr_ctrl_byte_r <= ciadc_pkg::CTRL_RESET;
      wr_dac_byte_r <= ciadc_pkg::DAC_RESET;
      ctrl_tgl_r <= 1'b0;
      dac_tgl_r <= 1'b0;
      conv_tgl_r <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
    end else if (start_ev) begin
      lk_state_r <= ciadc_pkg::LK_ADDR;
      bit_cnt_r <= 4'h0;
      wr_idx_r <= 2'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_ev) begin
      lk_state_r <= ciadc_pkg::LK_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (lk_state_r)
        ciadc_pkg::LK_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ciadc_pkg::LK_ADDR, ciadc_pkg::LK_WR_BYTE: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            if (lk_state_r == ciadc_pkg::LK_ADDR) begin
              if (shift_r[7:1] == {ADDR_FIXED, asel_s}) begin
                rw_r <= shift_r[0];
                sda_oe_n <= 1'b0;
                lk_state_r <= ciadc_pkg::LK_ADDR_ACK;
              end else begin
                lk_state_r <= ciadc_pkg::LK_IDLE;
              end
            end else begin
              if (wr_idx_r == 2'h0) begin
                wr_ctrl_byte_r <= shift_r;
                ctrl_tgl_r <= !ctrl_tgl_r;
                wr_idx_r <= 2'h1;
              end else begin
                wr_dac_byte_r <= shift_r;
                dac_tgl_r <= !dac_tgl_r;
                wr_idx_r <= 2'h2;
              end
              sda_oe_n <= 1'b0;
              lk_state_r <= ciadc_pkg::LK_WR_ACK;
            end
          end
        end
        ciadc_pkg::LK_ADDR_ACK, ciadc_pkg::LK_RD_ACKED: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              sda_oe_n <= last_res_r[7];
              tx_r <= {last_res_r[6:0], 1'b0};
              conv_tgl_r <= !conv_tgl_r;
              lk_state_r <= ciadc_pkg::LK_RD_BYTE;
            end else begin
              sda_oe_n <= 1'b1;
              lk_state_r <= ciadc_pkg::LK_WR_BYTE;
            end
          end
        end
        ciadc_pkg::LK_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            bit_cnt_r <= 4'h0;
            lk_state_r <= ciadc_pkg::LK_WR_BYTE;
          end
        end
        ciadc_pkg::LK_RD_BYTE: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'h7) begin
              sda_oe_n <= 1'b1;
              lk_state_r <= ciadc_pkg::LK_RD_ACK;
            end else begin
              sda_oe_n <= tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
        end
        ciadc_pkg::LK_RD_ACK: begin
          if (scl_rise) begin
            if (!sda_s) begin
              lk_state_r <= ciadc_pkg::LK_RD_ACKED;
            end else begin
              lk_state_r <= ciadc_pkg::LK_WAIT_STOP;
            end
          end
        end
        ciadc_pkg::LK_WAIT_STOP: begin
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Link copy of the newest result; the core holds the word steady meanwhile.
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      last_res_r <= ciadc_pkg::ADC_RESET;
    end else if (done_s != done_q) begin
      last_res_r <= adc_result_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Core domain: synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] tg_m, tg_s, tg_q;
  logic cmp_m, cmp_s;
  logic src_m, src_s;
  logic oscin_m, oscin_s, oscin_q;

  // Toggles from the link and all pins pass two flops first.
  always_ff @(posedge clock) begin
    tg_m <= {conv_tgl_r, dac_tgl_r, ctrl_tgl_r};
    tg_s <= tg_m;
    tg_q <= tg_s;
    cmp_m <= comparator_high;
    cmp_s <= cmp_m;
    src_m <= clock_source_select;
    src_s <= src_m;
    oscin_m <= oscillator_pin_i;
    oscin_s <= oscin_m;
    oscin_q <= oscin_s;
  end

  logic ctrl_ev, dac_ev, conv_ev;

  assign ctrl_ev = tg_s[0] != tg_q[0];
  assign dac_ev = tg_s[1] != tg_q[1];
  assign conv_ev = tg_s[2] != tg_q[2];

  // ---------------------------------------------------------------------------
  // Core domain: conversion clock
  // ---------------------------------------------------------------------------
  logic osc_run;
  logic [7:0] osc_cnt_r;
  logic osc_level_r;
  logic step_r;
  logic sar_busy, sar_done;
  logic [7:0] sar_trial, sar_result;
  logic [7:0] ctrl_r;

  assign osc_run = ctrl_r[ciadc_pkg::CTRL_AOE_BIT] || sar_busy;

  // Internal oscillator divider, stopped when idle or fed from outside.
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_cnt_r <= 8'h00;
      osc_level_r <= 1'b0;
    end else if (!osc_run || src_s) begin
      osc_cnt_r <= 8'h00;
      osc_level_r <= 1'b0;
    end else if (osc_cnt_r == ciadc_pkg::OSC_HALF_LAST) begin
      osc_cnt_r <= 8'h00;
      osc_level_r <= !osc_level_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end
  end

  // One step per conversion clock period from whichever source is chosen.
  always_ff @(posedge clock) begin
    if (rst) begin
      step_r <= 1'b0;
    end else if (src_s) begin
      step_r <= oscin_s && !oscin_q;
    end else begin
      step_r <= osc_run && !osc_level_r && (osc_cnt_r == ciadc_pkg::OSC_HALF_LAST);
    end
  end

  // Oscillator pin drives the internal clock while it runs; floats when stopped or for an outside one.
  always_ff @(posedge clock) begin
    if (rst) begin
      oscillator_pin_o <= 1'b0;
      oscillator_pin_oe_n <= 1'b1;
      osc_enable <= 1'b0;
    end else begin
      oscillator_pin_o <= osc_level_r;
      oscillator_pin_oe_n <= src_s || !osc_run;
      osc_enable <= osc_run && !src_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Core domain: registers and conversion sequencing
  // ---------------------------------------------------------------------------
  logic [7:0] dac_r;
  logic [1:0] conv_chan_r;
  logic conv_diff_r;
  logic [1:0] next_chan;

  ciadc_sar u_sar (
    .clock(clock),
    .rst(rst),
    .start(conv_ev),
    .step(step_r),
    .comp_high(cmp_s),
    .busy(sar_busy),
    .trial(sar_trial),
    .result(sar_result),
    .done(sar_done)
  );

  // Channel after the one just converted, wrapping past the highest.
  assign next_chan = (conv_chan_r == ciadc_pkg::chan_max(ctrl_r[ciadc_pkg::CTRL_MODE_LSB +: 2]))
                     ? 2'h0 : conv_chan_r + 2'h1;

  // Control register; a fresh write wins over a same-cycle auto-increment.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= ciadc_pkg::CTRL_RESET;
    end else if (ctrl_ev) begin
      ctrl_r <= wr_ctrl_byte_r;
    end else if (sar_done && ctrl_r[ciadc_pkg::CTRL_AINC_BIT]) begin
      ctrl_r[ciadc_pkg::CTRL_CHAN_LSB +: 2] <= next_chan;
    end
  end

  // DAC value stays put until another data byte arrives.
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_r <= ciadc_pkg::DAC_RESET;
    end else if (dac_ev) begin
      dac_r <= wr_dac_byte_r;
    end
  end

  // Latch the channel at the start and publish the coded result at the end.
  always_ff @(posedge clock) begin
    if (rst) begin
      conv_chan_r <= 2'h0;
      conv_diff_r <= 1'b0;
      adc_result_r <= ciadc_pkg::ADC_RESET;
      done_tgl_r <= 1'b0;
    end else begin
      if (conv_ev && !sar_busy) begin
        conv_chan_r <= ciadc_pkg::chan_eff(ctrl_r);
        conv_diff_r <= ciadc_pkg::chan_is_diff(ctrl_r[ciadc_pkg::CTRL_MODE_LSB +: 2],
                                               ciadc_pkg::chan_eff(ctrl_r));
      end
      if (sar_done) begin
        adc_result_r <= conv_diff_r ? {!sar_result[7], sar_result[6:0]} : sar_result;
        done_tgl_r <= !done_tgl_r;
      end
    end
  end

  // Analog-side controls; the DAC carries trial codes during a conversion.
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_tap <= ciadc_pkg::DAC_RESET;
      analog_output_enable <= 1'b0;
      track_hold <= 1'b0;
      sample_strobe <= 1'b0;
      channel_select <= 2'h0;
      input_mode <= 2'h0;
      adc_busy <= 1'b0;
      control_value <= ciadc_pkg::CTRL_RESET;
    end else begin
      dac_tap <= sar_busy ? sar_trial : dac_r;
      analog_output_enable <= ctrl_r[ciadc_pkg::CTRL_AOE_BIT];
      track_hold <= sar_busy || (conv_ev && !sar_busy);
      sample_strobe <= conv_ev && !sar_busy;
      channel_select <= sar_busy ? conv_chan_r : ciadc_pkg::chan_eff(ctrl_r);
      input_mode <= ctrl_r[ciadc_pkg::CTRL_MODE_LSB +: 2];
      adc_busy <= sar_busy;
      control_value <= ctrl_r;
    end
  end

endmodule

// ==== ciadc_chk.sv ====
// Checker for the converter controller: timing relations seen at the top ports.
// Assumes it is bound to ciadc_top; bus checks run on link_clk, the rest on clock.
`timescale 1ns/1ps
module ciadc_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_oe_n,
  input wire logic clock_source_select,
  input wire logic oscillator_pin_oe_n,
  input wire logic analog_output_enable,
  input wire logic track_hold,
  input wire logic sample_strobe,
  input wire logic [1:0] channel_select,
  input wire logic [1:0] input_mode,
  input wire logic osc_enable,
  input wire logic adc_busy,
  input wire logic [7:0] control_value
);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [11:0] busy_cnt_r;

  // Counts the cycles of the conversion in progress.
  always_ff @(posedge clock) begin
    if (rst || !adc_busy) begin
      busy_cnt_r <= 12'h000;
    end else begin
      busy_cnt_r <= busy_cnt_r + 12'h001;
    end
  end

  // A conversion opens with the sample pulse and hold, then busy rises a cycle later.
  sequence conv_begin;
    sample_strobe ##[0:2] (adc_busy && track_hold);
  endsequence

  // The control register has not moved for two cycles.
  sequence ctrl_settled;
    $stable(control_value) [*2];
  endsequence

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_reset_clears_all: assert property (disable iff (1'b0) rst |=>
    control_value == 8'h00 && !analog_output_enable && !osc_enable && oscillator_pin_oe_n)
    else $error("reset left a control output set");
  a_aoe_from_bit6: assert property (analog_output_enable == control_value[6])
    else $error("output enable does not follow control bit 6");
  a_osc_kept_running: assert property ((control_value[6] && !clock_source_select) [*5]
    |-> osc_enable) else $error("oscillator stopped while output enable set");
  a_osc_pin_internal: assert property ((!clock_source_select && osc_enable) [*5]
    |-> !oscillator_pin_oe_n) else $error("internal oscillator not driven on its pin");
  a_osc_pin_external: assert property (clock_source_select [*5] |-> oscillator_pin_oe_n)
    else $error("oscillator pin driven in external clock mode");
  a_conv_start_hold: assert property (sample_strobe |-> conv_begin)
    else $error("conversion start without busy and hold");
  a_strobe_one_cycle: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample pulse longer than one cycle");
  a_conv_length: assert property (busy_cnt_r < 12'h4B0)
    else $error("conversion runs too long");
  a_chan_exists: assert property (ctrl_settled ##0 !adc_busy |->
    channel_select <= ((input_mode == 2'h3) ? 2'h1 : (input_mode == 2'h0) ? 2'h3 : 2'h2))
    else $error("selected channel does not exist in this mode");
  a_mode_from_ctrl: assert property (ctrl_settled |-> input_mode == control_value[5:4])
    else $error("input mode differs from control bits");
  a_sda_still_scl_high: assert property (@(posedge link_clk) disable iff (rst)
    scl && $past(scl) |-> $stable(sda_oe_n)) else $error("data line moved while clock high");
endmodule

bind ciadc_top ciadc_chk chk_i (.clock, .rst, .link_clk, .scl, .sda_oe_n,
  .clock_source_select, .oscillator_pin_oe_n, .analog_output_enable, .track_hold,
  .sample_strobe, .channel_select, .input_mode, .osc_enable, .adc_busy, .control_value);

// ==== ciadc_master.sv ====
// Behavioural two-wire bus master that faces the converter controller.
// Assumes an external pull-up: the bench resolves the line from sda_low and the device.
`timescale 1ns/1ps
module ciadc_master #(
  parameter int QUARTER_NS = 1000
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Bus idles with both lines high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start, or repeated start from a low clock: data falls while clock is high.
  task automatic start();
    sda_low = 1'b0;
    #QUARTER_NS;
    scl = 1'b1;
    #QUARTER_NS;
    sda_low = 1'b1;
    #QUARTER_NS;
    scl = 1'b0;
    #QUARTER_NS;
  endtask

  // Stop: data rises while clock is high, leaving the bus idle.
  task automatic stop();
    sda_low = 1'b1;
    #QUARTER_NS;
    scl = 1'b1;
    #QUARTER_NS;
    sda_low = 1'b0;
    #QUARTER_NS;
  endtask

  // One clock pulse; data changes only while the clock is low.
  task automatic xfer_bit(input logic b, output logic r);
    sda_low = !b;
    #QUARTER_NS;
    scl = 1'b1;
    #QUARTER_NS;
    r = sda;
    #QUARTER_NS;
    scl = 1'b0;
    #QUARTER_NS;
  endtask

  // Sends a byte most significant bit first and returns the acknowledge level.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, ack);
  endtask

  // Reads a byte, then acknowledges it or not.
  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(nack, r);
  endtask
endmodule

// ==== ciadc_top_tb.sv ====
// Self-checking bench for the converter controller with a bus master model.
// Assumes fixed address bits at their default; comparator modelled from fixed levels.
`timescale 1ns/1ps
module ciadc_top_tb;
  logic clock, rst, link_clk, scl, sda_low, sda_line, sda_o, sda_oe_n;
  logic clock_source_select, osc_ext, osc_o, osc_oe_n, comparator_high;
  logic analog_output_enable, track_hold, sample_strobe, osc_enable, adc_busy;
  logic [7:0] dac_tap, control_value;
  logic [1:0] channel_select, input_mode;
  logic [7:0] lvl [4] = '{8'h3A, 8'hC5, 8'h01, 8'hFE};
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  // Open-drain line with pull-up; the comparator sees the selected input level.
  assign sda_line = !(sda_low || !sda_oe_n);
  assign comparator_high = (lvl[channel_select] >= dac_tap);

  ciadc_top ciadc_top_i (.clock(clock), .rst(rst), .link_clk(link_clk), .scl(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .address_select_0(1'b1),
    .address_select_1(1'b0), .address_select_2(1'b1),
    .clock_source_select(clock_source_select), .oscillator_pin_i(osc_ext),
    .oscillator_pin_o(osc_o), .oscillator_pin_oe_n(osc_oe_n),
    .comparator_high(comparator_high), .dac_tap(dac_tap),
    .analog_output_enable(analog_output_enable), .track_hold(track_hold),
    .sample_strobe(sample_strobe), .channel_select(channel_select),
    .input_mode(input_mode), .osc_enable(osc_enable), .adc_busy(adc_busy),
    .control_value(control_value));
  ciadc_master ciadc_master_i (.scl(scl), .sda_low(sda_low), .sda(sda_line));

  // ---------------------------------------------------------------------------
  // Clocks, timeout and reporting
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  initial begin
    osc_ext = 1'b0;
    forever #500 osc_ext = ~osc_ext;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      test_done();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Control byte then two DAC bytes in one write.
  task automatic t_write();
    logic ack;
    ciadc_master_i.start();
    ciadc_master_i.wbyte(8'h5A, ack);
    check({7'h00, ack}, 8'h00);
    ciadc_master_i.wbyte(8'h44, ack);
    check({7'h00, ack}, 8'h00);
    check(control_value, 8'h44);
    ciadc_master_i.wbyte(8'hA5, ack);
    check(dac_tap, 8'hA5);
    ciadc_master_i.wbyte(8'h3C, ack);
    ciadc_master_i.stop();
    check(dac_tap, 8'h3C);
    check({6'h00, input_mode}, 8'h00);
    check({6'h00, analog_output_enable, osc_enable}, 8'h03);
    check({7'h00, osc_oe_n}, 8'h00);
    check({7'h00, sda_o}, 8'h00);
  endtask

  // Another strap setting is ignored.
  task automatic t_bad_addr();
    logic ack;
    ciadc_master_i.start();
    ciadc_master_i.wbyte(8'h58, ack);
    check({7'h00, ack}, 8'h01);
    ciadc_master_i.stop();
  endtask

  // Auto-increment read over four single-ended channels, ended by a refusal.
  task automatic t_read();
    logic ack;
    logic [7:0] d;
    ciadc_master_i.start();
    ciadc_master_i.wbyte(8'h5B, ack);
    check({7'h00, ack}, 8'h00);
    ciadc_master_i.rbyte(d, 1'b0);
    check(d, 8'h80);
    for (int i = 0; i < 4; i++) begin
      ciadc_master_i.rbyte(d, i == 3);
      check(d, lvl[i]);
    end
    check({7'h00, sda_oe_n}, 8'h01);
    ciadc_master_i.stop();
    repeat (2000) @(negedge clock);
    check(dac_tap, 8'h3C);
  endtask

  // Oscillator pin released for an external clock, driven again for internal.
  task automatic t_ext();
    clock_source_select = 1'b1;
    repeat (20) @(negedge clock);
    check({7'h00, osc_oe_n}, 8'h01);
    clock_source_select = 1'b0;
    repeat (20) @(negedge clock);
    check({7'h00, osc_oe_n}, 8'h00);
  endtask

  // Differential mode, missing channel, wrap to zero; write closed by a new start.
  task automatic t_diff();
    logic ack;
    logic [7:0] d;
    ciadc_master_i.start();
    ciadc_master_i.wbyte(8'h5A, ack);
    ciadc_master_i.wbyte(8'h17, ack);
    ciadc_master_i.start();
    ciadc_master_i.wbyte(8'h5B, ack);
    check({7'h00, ack}, 8'h00);
    check(control_value, 8'h17);
    ciadc_master_i.rbyte(d, 1'b0);
    ciadc_master_i.rbyte(d, 1'b0);
    check(d, lvl[2] ^ 8'h80);
    ciadc_master_i.rbyte(d, 1'b1);
    check(d, lvl[0] ^ 8'h80);
    ciadc_master_i.stop();
  endtask

  // Main sequence; reset also spans enough link clock edges.
  initial begin
    rst = 1'b1;
    clock_source_select = 1'b0;
    repeat (70) @(negedge clock);
    rst = 1'b0;
    check(control_value, 8'h00);
    check({dac_tap[6:0], osc_oe_n}, 8'h01);
    check({5'h00, sda_oe_n, analog_output_enable, osc_enable}, 8'h04);
    repeat (100) @(negedge clock);
    t_write();
    t_bad_addr();
    t_read();
    t_ext();
    t_diff();
    test_done();
  end
endmodule
